// >>> fieldbus_pkg.sv
// shared constants, timing figures and data helpers for the channel mapper
package fieldbus_pkg;
  localparam int CLK_MHZ = 10;
  localparam int T_RAM_US = 500;
  localparam int T_BACKUP_US = 17000;
  localparam int T_SAVE_US = 120000;
  localparam int T_INSTR_US = 500;
  localparam int T_GET_US = 50000;
  localparam int T_SET_US = 500;
  localparam int T_KEY_US = 80000;
  localparam int NSLOT = 16;
  localparam logic [5:0] CODE_NONE = 6'h00;
  localparam logic [5:0] CODE_MV_HEAT = 6'h03;
  localparam logic [5:0] CODE_TUNE_LAST = 6'h23;
  localparam logic [5:0] CODE_INSTR = 6'h24;
  localparam logic [5:0] CODE_STATUS_A = 6'h25;
  localparam logic [5:0] CODE_LAST = 6'h28;
  localparam logic [11:0] A_CONFIG = 12'h000;
  localparam logic [11:0] A_MODE = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;
  localparam logic [11:0] A_STOP_MV = 12'h00C;
  localparam logic [11:0] A_WSLOT = 12'h040;
  localparam logic [11:0] A_RSLOT = 12'h080;
  localparam logic [11:0] A_PARAM = 12'h100;
  localparam int CFG_BCD = 0;
  localparam int CFG_STOP = 1;
  localparam int CFG_RATE = 2;
  localparam int CFG_NODE = 4;
  localparam int MODE_REMOTE = 0;
  localparam int MODE_BACKUP = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DUP = 1;
  localparam int ST_NET = 2;
  localparam int ST_DIR = 3;
  localparam int ST_STOP = 4;
  localparam int OI_REMOTE = 1;
  localparam int OI_BACKUP = 2;
  localparam int OI_SAVE = 3;
  localparam int OI_STB1 = 14;
  localparam int OI_STB2 = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RATE_125K = 2'b00,
    RATE_250K = 2'b01,
    RATE_500K = 2'b10
  } rate_t;
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_RAM = 3'b001,
    K_BACKUP = 3'b010,
    K_SAVE = 3'b011,
    K_INSTR = 3'b100,
    K_GET = 3'b101,
    K_SET = 3'b110
  } kind_t;
  localparam logic [5:0] DEF_WSLOT [4] = '{6'h06, 6'h07, 6'h08, 6'h24};
  localparam logic [5:0] DEF_RSLOT [3] = '{6'h01, 6'h03, 6'h25};

  function automatic logic read_only(input logic [5:0] c);
    return (c >= 6'h01 && c <= 6'h05) || c == 6'h14 ||
      (c >= CODE_STATUS_A && c <= CODE_LAST);
  endfunction

  function automatic logic [15:0] to_bcd(input logic [15:0] v);
    logic [15:0] m;
    logic [3:0] lead;
    m = v[15] ? 16'(16'h0000 - v) : v;
    lead = 4'((m / 16'h03E8) % 16'h000A);
    if (v[15]) lead = (m >= 16'h03E8) ? 4'hA : 4'hF;
    return {lead, 4'((m / 16'h0064) % 16'h000A),
      4'((m / 16'h000A) % 16'h000A), 4'(m % 16'h000A)};
  endfunction

  function automatic logic [15:0] from_bcd(input logic [15:0] b);
    logic [15:0] m;
    m = 16'(b[11:8] * 16'h0064) + 16'(b[7:4] * 16'h000A) + 16'(b[3:0]);
    if (b[15:12] == 4'hA) return 16'(16'h0000 - (m + 16'h03E8));
    if (b[15:12] == 4'hF) return 16'(16'h0000 - m);
    return 16'(16'(b[15:12] * 16'h03E8) + m);
  endfunction
endpackage

// >>> fieldbus_channel_mapper.sv
// channel mapper: slot tables, parameter store, timing and register slave
// Overview of operation
// RQ1: in volatile mode each written data item completes in 0.5 ms.
// RQ2: with nonvolatile backup each written data item takes 17 ms.
// RQ3: save-to-nonvolatile operation instruction takes 120 ms.
// RQ4: every other operation instruction completes in 0.5 ms.
// RQ5: explicit attribute read takes 50 ms, attribute write 0.5 ms.
// RQ6: key switching between remote and local adds up to 80 ms.
// RQ7: bit rate selectable 125, 250 or 500 kbit/s, default 125.
// RQ8: the master and all nodes use one common bit rate.
// RQ9: node address 0 to 63, default 0.
// RQ10: master keeps this node's channels clear of other nodes' channels.
// RQ11: sixteen write and sixteen read slots hold codes 1-40 or none.
// RQ12: an unassigned slot amid assigned ones still occupies a channel, value 0.
// RQ13: unassigned slots trailing from slot 16 shrink the channel count.
// RQ14: all slots unassigned raises a network error.
// RQ15: at power-up a code repeated within one direction flags an error.
// RQ16: wrong-direction code in a slot is refused with a mismatch flag.
// RQ17: monitor codes are read-only, valid only in read slots.
// RQ18: tuning and limit codes up to 35 are read/write in both areas.
// RQ19: code 36 is write-only, codes 37 to 40 read-only.
// RQ20: values are plain binary or packed decimal, default binary.
// RQ21: on communication error keep running or stop with stop-time output.
// RQ22: written channel data is taken only in remote mode.
// RQ23: packed decimal uses A for leading minus one, F for minus.
// RQ24: each channel is one 16-bit word, sent in slot order from one.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fieldbus_channel_mapper #(
  parameter int CYC_RAM = fieldbus_pkg::T_RAM_US * fieldbus_pkg::CLK_MHZ,
  parameter int CYC_BACKUP = fieldbus_pkg::T_BACKUP_US * fieldbus_pkg::CLK_MHZ,
  parameter int CYC_SAVE = fieldbus_pkg::T_SAVE_US * fieldbus_pkg::CLK_MHZ,
  parameter int CYC_INSTR = fieldbus_pkg::T_INSTR_US * fieldbus_pkg::CLK_MHZ,
  parameter int CYC_GET = fieldbus_pkg::T_GET_US * fieldbus_pkg::CLK_MHZ,
  parameter int CYC_SET = fieldbus_pkg::T_SET_US * fieldbus_pkg::CLK_MHZ,
  parameter int CYC_KEY = fieldbus_pkg::T_KEY_US * fieldbus_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // channels written by the master
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [3:0] wr_slot,
  input wire logic [15:0] wr_data,
  // channels read by the master
  input wire logic [3:0] rd_slot,
  output logic [15:0] rd_data,
  output logic [4:0] wr_count,
  output logic [4:0] rd_count,
  // explicit attribute services
  input wire logic ex_valid,
  output logic ex_ready,
  input wire logic ex_get,
  input wire logic [5:0] ex_code,
  input wire logic [15:0] ex_wdata,
  output logic ex_done,
  output logic [15:0] ex_rdata,
  // device pins and settings
  input wire logic comm_error,
  input wire logic key_switch,
  output logic net_error,
  output logic dup_error,
  output logic stopped,
  output logic [15:0] mv_out,
  output logic [1:0] bit_rate,
  output logic [5:0] node_addr
);
  typedef struct packed {
    logic awv;
    logic [11:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic fmt_bcd;
    logic stop_on_err;
    logic [1:0] rate;
    logic [5:0] node;
    logic remote;
    logic backup;
    logic dir_mis;
    logic dup_err;
    logic checked;
    logic [15:0] stop_mv;
    logic [31:0][5:0] slot;
    logic [40:0][15:0] param;
    logic [21:0] timer;
    logic busy;
    logic ex_pend;
    logic ex_done;
    logic [15:0] ex_data;
    logic key_pend;
    logic [1:0] err_s;
    logic [2:0] key_s;
    logic stopped;
    logic [15:0] mv_out;
    logic [15:0] rdd;
  } state_t;

  function automatic state_t reset_state();
    state_t r;
    r = '0;
    for (int i = 0; i < 4; i++) r.slot[i] = fieldbus_pkg::DEF_WSLOT[i];
    for (int i = 0; i < 3; i++) r.slot[16 + i] = fieldbus_pkg::DEF_RSLOT[i];
    r.rate = fieldbus_pkg::RATE_125K;
    return r;
  endfunction

  function automatic logic [4:0] used_count(input logic [15:0][5:0] sl);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < fieldbus_pkg::NSLOT; i++)
      if (sl[i] != fieldbus_pkg::CODE_NONE) c = 5'(i + 1);
    return c;
  endfunction

  function automatic logic has_dup(input logic [15:0][5:0] sl);
    logic d;
    d = 1'b0;
    for (int i = 0; i < fieldbus_pkg::NSLOT; i++)
      for (int j = i + 1; j < fieldbus_pkg::NSLOT; j++)
        if (sl[i] != fieldbus_pkg::CODE_NONE && sl[i] == sl[j]) d = 1'b1;
    return d;
  endfunction

  function automatic logic [32:0] reg_value(input state_t st,
                                            input logic [11:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a == fieldbus_pkg::A_CONFIG)
      r[31:0] = 32'({st.node, st.rate, st.stop_on_err, st.fmt_bcd});
    else if (a == fieldbus_pkg::A_MODE)
      r[31:0] = 32'({st.backup, st.remote});
    else if (a == fieldbus_pkg::A_STATUS)
      r[31:0] = 32'({st.stopped, st.dir_mis,
        used_count(st.slot[15:0]) == 5'h00 &&
        used_count(st.slot[31:16]) == 5'h00, st.dup_err, st.busy});
    else if (a == fieldbus_pkg::A_STOP_MV)
      r[31:0] = 32'(st.stop_mv);
    else if (a >= fieldbus_pkg::A_WSLOT && a < fieldbus_pkg::A_PARAM)
      r[31:0] = 32'(st.slot[{a[7], a[5:2]}]);
    else if (a > fieldbus_pkg::A_PARAM &&
             a <= fieldbus_pkg::A_PARAM + 12'(fieldbus_pkg::CODE_LAST * 4))
      r[31:0] = 32'(st.param[6'(a[7:2])]);
    else
      r[32] = 1'b0;
    if (a[1:0] != 2'b00) r = 33'h0_0000_0000;
    return r;
  endfunction

  state_t s, n;
  logic [32:0] wr_old, rd_val;
  logic [31:0] wmerge;
  logic wr_take, ex_take, key_edge;
  logic [5:0] wcode, rcode;
  logic [15:0] wval;
  fieldbus_pkg::kind_t kind;
  logic [21:0] len;

  assign awready = !s.awv && !s.bv;
  assign wready = !s.wv && !s.bv;
  assign bvalid = s.bv;
  assign bresp = s.br;
  assign arready = !s.rv;
  assign rvalid = s.rv;
  assign rdata = s.rd;
  assign rresp = s.rr;
  assign wr_ready = !s.busy;
  assign ex_ready = !s.busy && !wr_valid;
  assign ex_done = s.ex_done;
  assign ex_rdata = s.ex_data;
  assign rd_data = s.rdd;
  assign stopped = s.stopped;
  assign mv_out = s.mv_out;
  assign bit_rate = s.rate;
  assign node_addr = s.node;
  assign dup_error = s.dup_err;
  // RQ13 trailing slots shrink
  assign wr_count = used_count(s.slot[15:0]);
  assign rd_count = used_count(s.slot[31:16]);
  // RQ14 all slots unassigned
  assign net_error = wr_count == 5'h00 && rd_count == 5'h00;

  always_comb begin
    n = s;
    n.ex_done = 1'b0;
    n.err_s = {s.err_s[0], comm_error};
    n.key_s = {s.key_s[1:0], key_switch};
    key_edge = s.key_s[1] && !s.key_s[2];
    wr_old = reg_value(s, s.awa);
    for (int b = 0; b < 4; b++)
      wmerge[b*8 +: 8] = s.ws[b] ? s.wd[b*8 +: 8] : wr_old[b*8 +: 8];
    rd_val = reg_value(s, araddr);
    wr_take = wr_valid && !s.busy;
    ex_take = ex_valid && ex_ready;
    wcode = s.slot[wr_slot];
    // RQ20 binary or packed decimal
    wval = s.fmt_bcd ? fieldbus_pkg::from_bcd(wr_data) : wr_data;
    kind = fieldbus_pkg::K_NONE;
    // register slave
    if (awvalid && awready) begin
      n.awv = 1'b1;
      n.awa = awaddr;
    end
    if (wvalid && wready) begin
      n.wv = 1'b1;
      n.wd = wdata;
      n.ws = wstrb;
    end
    if (s.awv && s.wv) begin
      n.awv = 1'b0;
      n.wv = 1'b0;
      n.bv = 1'b1;
      n.br = wr_old[32] ? fieldbus_pkg::RESP_OKAY : fieldbus_pkg::RESP_SLVERR;
      if (s.awa == fieldbus_pkg::A_CONFIG) begin
        n.fmt_bcd = wmerge[fieldbus_pkg::CFG_BCD];
        n.stop_on_err = wmerge[fieldbus_pkg::CFG_STOP];
        // RQ7 reserved rate code refused
        if (wmerge[fieldbus_pkg::CFG_RATE +: 2] != 2'b11)
          n.rate = wmerge[fieldbus_pkg::CFG_RATE +: 2];
        // RQ9 six-bit node address
        n.node = wmerge[fieldbus_pkg::CFG_NODE +: 6];
      end else if (s.awa == fieldbus_pkg::A_MODE) begin
        n.remote = wmerge[fieldbus_pkg::MODE_REMOTE];
        n.backup = wmerge[fieldbus_pkg::MODE_BACKUP];
      end else if (s.awa == fieldbus_pkg::A_STATUS) begin
        if (wmerge[fieldbus_pkg::ST_DIR]) n.dir_mis = 1'b0;
      end else if (s.awa == fieldbus_pkg::A_STOP_MV) begin
        n.stop_mv = wmerge[15:0];
      end else if (wr_old[32] && s.awa >= fieldbus_pkg::A_WSLOT &&
                   s.awa < fieldbus_pkg::A_PARAM) begin
        // RQ11 codes 1 to 40
        // RQ16 RQ17 RQ19 refuse wrong direction
        if (wmerge[5:0] > fieldbus_pkg::CODE_LAST ||
            (!s.awa[7] && fieldbus_pkg::read_only(wmerge[5:0])) ||
            (s.awa[7] && wmerge[5:0] == fieldbus_pkg::CODE_INSTR))
          n.dir_mis = 1'b1;
        else
          n.slot[{s.awa[7], s.awa[5:2]}] = wmerge[5:0];
      end else if (wr_old[32]) begin
        n.param[6'(s.awa[7:2])] = wmerge[15:0];
      end
    end
    if (s.bv && bready) n.bv = 1'b0;
    if (arvalid && arready) begin
      n.rv = 1'b1;
      n.rd = rd_val[31:0];
      n.rr = rd_val[32] ? fieldbus_pkg::RESP_OKAY : fieldbus_pkg::RESP_SLVERR;
    end
    if (s.rv && rready) n.rv = 1'b0;
    // RQ15 power-up duplicate check
    if (!s.checked) begin
      n.checked = 1'b1;
      n.dup_err = has_dup(s.slot[15:0]) || has_dup(s.slot[31:16]);
    end
    // cyclic channel write from the master
    if (wr_take && {1'b0, wr_slot} < wr_count &&
        wcode != fieldbus_pkg::CODE_NONE) begin
      if (wcode == fieldbus_pkg::CODE_INSTR) begin
        if (wr_data[fieldbus_pkg::OI_STB1] == wr_data[fieldbus_pkg::OI_STB2])
        begin
          n.remote = wr_data[fieldbus_pkg::OI_REMOTE];
          n.backup = wr_data[fieldbus_pkg::OI_BACKUP];
        end
        // RQ3 save instruction
        // RQ4 other instructions
        kind = wr_data[fieldbus_pkg::OI_SAVE] ?
          fieldbus_pkg::K_SAVE : fieldbus_pkg::K_INSTR;
      end else if (s.remote) begin
        // RQ22 remote mode only
        n.param[wcode] = wval;
        // RQ1 volatile write time
        // RQ2 backup write time
        kind = s.backup ? fieldbus_pkg::K_BACKUP : fieldbus_pkg::K_RAM;
      end
    end
    // RQ5 explicit services
    if (ex_take) begin
      n.ex_pend = 1'b1;
      n.ex_data = 16'h0000;
      if (ex_get) begin
        kind = fieldbus_pkg::K_GET;
        if (ex_code != fieldbus_pkg::CODE_NONE &&
            ex_code <= fieldbus_pkg::CODE_LAST)
          n.ex_data = s.fmt_bcd ? fieldbus_pkg::to_bcd(s.param[ex_code]) :
            s.param[ex_code];
      end else begin
        kind = fieldbus_pkg::K_SET;
        // RQ18 tuning codes writable
        if (s.remote && ex_code != fieldbus_pkg::CODE_NONE &&
            ex_code <= fieldbus_pkg::CODE_TUNE_LAST &&
            !fieldbus_pkg::read_only(ex_code))
          n.param[ex_code] = s.fmt_bcd ? fieldbus_pkg::from_bcd(ex_wdata) :
            ex_wdata;
      end
    end
    unique case (kind)
      fieldbus_pkg::K_NONE: len = 22'h000000;
      fieldbus_pkg::K_RAM: len = 22'(CYC_RAM);
      fieldbus_pkg::K_BACKUP: len = 22'(CYC_BACKUP);
      fieldbus_pkg::K_SAVE: len = 22'(CYC_SAVE);
      fieldbus_pkg::K_INSTR: len = 22'(CYC_INSTR);
      fieldbus_pkg::K_GET: len = 22'(CYC_GET);
      fieldbus_pkg::K_SET: len = 22'(CYC_SET);
      default: len = 22'h000000;
    endcase
    // RQ6 key switch extra delay
    if (kind != fieldbus_pkg::K_NONE && s.key_pend) begin
      len = len + 22'(CYC_KEY);
      n.key_pend = 1'b0;
    end
    if (key_edge) begin
      n.remote = !n.remote;
      n.key_pend = 1'b1;
    end
    if (kind != fieldbus_pkg::K_NONE) begin
      n.busy = 1'b1;
      n.timer = len;
    end else if (s.busy) begin
      n.timer = s.timer - 22'h000001;
      if (s.timer == 22'h000001) begin
        n.busy = 1'b0;
        n.ex_done = s.ex_pend;
        n.ex_pend = 1'b0;
      end
    end
    // RQ21 stop on communication error
    n.stopped = s.stop_on_err && s.err_s[1];
    n.mv_out = n.stopped ? s.stop_mv : s.param[fieldbus_pkg::CODE_MV_HEAT];
    // RQ12 unassigned slot reads zero
    // RQ24 one word per slot
    rcode = s.slot[16 + rd_slot];
    if ({1'b0, rd_slot} >= rd_count || rcode == fieldbus_pkg::CODE_NONE ||
        rcode > fieldbus_pkg::CODE_LAST)
      n.rdd = 16'h0000;
    else
      // RQ23 signed packed decimal
      n.rdd = s.fmt_bcd ? fieldbus_pkg::to_bcd(s.param[rcode]) :
        s.param[rcode];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s <= reset_state();
    else s <= n;
  end

  // checking helpers: busy length and the kind of job that started it
  logic [21:0] hcnt;
  fieldbus_pkg::kind_t hkind;
  logic hkey;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcnt <= 22'h000000;
      hkind <= fieldbus_pkg::K_NONE;
      hkey <= 1'b0;
    end else begin
      hcnt <= (kind != fieldbus_pkg::K_NONE) ? 22'h000001 :
        (s.busy ? hcnt + 22'h000001 : 22'h000000);
      if (kind != fieldbus_pkg::K_NONE) begin
        hkind <= kind;
        hkey <= s.key_pend;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ram_write_time: assert property ( // RQ1
    $fell(s.busy) && hkind == fieldbus_pkg::K_RAM && !hkey
      |-> $past(hcnt) == 22'(CYC_RAM))
    else $error("volatile write time wrong");
  a_backup_write_time: assert property ( // RQ2
    $fell(s.busy) && hkind == fieldbus_pkg::K_BACKUP && !hkey
      |-> $past(hcnt) == 22'(CYC_BACKUP))
    else $error("backup write time wrong");
  a_save_instr_time: assert property ( // RQ3
    $fell(s.busy) && hkind == fieldbus_pkg::K_SAVE && !hkey
      |-> $past(hcnt) == 22'(CYC_SAVE))
    else $error("save instruction time wrong");
  a_plain_instr_time: assert property ( // RQ4
    $fell(s.busy) && hkind == fieldbus_pkg::K_INSTR && !hkey
      |-> $past(hcnt) == 22'(CYC_INSTR))
    else $error("instruction time wrong");
  a_explicit_get_done: assert property ( // RQ5
    $fell(s.busy) && hkind == fieldbus_pkg::K_GET && !hkey
      |-> $past(hcnt) == 22'(CYC_GET) && ex_done)
    else $error("explicit get time wrong");
  a_key_extra_delay: assert property ( // RQ6
    $fell(s.busy) && hkind == fieldbus_pkg::K_INSTR && hkey
      |-> $past(hcnt) == 22'(CYC_INSTR + CYC_KEY))
    else $error("key extra delay wrong");
  a_unassigned_reads_zero: assert property ( // RQ12
    s.slot[16 + rd_slot] == fieldbus_pkg::CODE_NONE |=> rd_data == 16'h0000)
    else $error("unassigned slot not zero");
  a_all_none_error: assert property ( // RQ14
    s.slot == '0 |-> net_error && wr_count == 5'h00)
    else $error("network error missing");
  a_dir_refused: assert property ( // RQ16
    s.awv && s.wv && s.awa == fieldbus_pkg::A_RSLOT &&
    s.ws[0] && s.wd[5:0] == fieldbus_pkg::CODE_INSTR
      |=> s.dir_mis && $stable(s.slot[16]))
    else $error("direction mismatch not refused");
  a_stop_output: assert property ( // RQ21
    s.stop_on_err && s.err_s[1] |=> stopped && mv_out == $past(s.stop_mv))
    else $error("stop output not driven");
  a_local_ignored: assert property ( // RQ22
    wr_take && !s.remote && !(s.awv && s.wv) &&
    wcode != fieldbus_pkg::CODE_INSTR |=> $stable(s.param))
    else $error("local mode write taken");

  c_save_instr: cover property (
    wr_take && kind == fieldbus_pkg::K_SAVE);
  c_explicit_done: cover property (ex_take ##[1:1000] ex_done);
  c_net_error: cover property (net_error);
  c_stopped: cover property ($rose(stopped));
endmodule

// >>> fieldbus_master_model.sv
// far-side network master model for the channel links
`timescale 1ns/1ps
module fieldbus_master_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [3:0] wr_slot,
  output logic [15:0] wr_data,
  // read channels
  output logic [3:0] rd_slot,
  input wire logic [15:0] rd_data
);
  initial {wr_valid, wr_slot, wr_data, rd_slot} = 25'h0;
  task automatic send(input logic [3:0] s, input logic [15:0] d,
                      input int gap, output int busy);
    repeat (gap + 1) @(posedge aclk);
    wr_slot <= s;
    wr_data <= d;
    wr_valid <= 1'b1;
    for (busy = 0; busy < 99; busy++) begin
      @(posedge aclk);
      if (wr_ready === 1'b1) break;
    end
    wr_valid <= 1'b0;
    wr_data <= ~d;
    // never taken: report an impossible length
    if (busy == 99) busy = -1;
    else
      for (busy = 0; busy < 2000; busy++) begin
        #1;
        if (wr_ready !== 1'b0) break;
        @(posedge aclk);
      end
  endtask
  task automatic peek(input logic [3:0] s, output logic [15:0] d);
    @(posedge aclk);
    rd_slot <= s;
    @(posedge aclk);
    #1;
    d = rd_data;
  endtask
endmodule

// >>> test_fieldbus_channel_mapper.sv
// self-checking bench for the channel mapper
`timescale 1ns/1ps
module test_fieldbus_channel_mapper;
  localparam int C_RAM = 5;
  localparam int C_BACK = 9;
  localparam int C_SAVE = 13;
  localparam int C_INSTR = 6;
  localparam int C_GET = 11;
  localparam int C_SET = 7;
  localparam int C_KEY = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready, ex_valid, ex_get;
  logic comm_error, key_switch, wr_valid, awready, wready, bvalid;
  logic arready, rvalid, wr_ready, ex_ready, ex_done, net_error;
  logic dup_error, stopped;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, wr_slot, rd_slot;
  logic [1:0] bresp, rresp, bit_rate;
  logic [15:0] wr_data, rd_data, ex_wdata, ex_rdata, mv_out;
  logic [4:0] wr_count, rd_count;
  logic [5:0] ex_code, node_addr;
  logic [15:0] seed = 16'hAE9C;
  logic [19:0] tbl [5] = '{20'h30006, 20'h0, 20'h30002, 20'h0, 20'h3000A};
  logic [5:0] bad [5] = '{6'h01, 6'h14, 6'h25, 6'h28, 6'h29};
  bit backup;
  int miscompares;
  int samples_checked;
  always #50 aclk = ~aclk;
  fieldbus_channel_mapper #(.CYC_RAM(C_RAM), .CYC_BACKUP(C_BACK),
    .CYC_SAVE(C_SAVE), .CYC_INSTR(C_INSTR), .CYC_GET(C_GET),
    .CYC_SET(C_SET), .CYC_KEY(C_KEY)) u_fieldbus_channel_mapper (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .wr_valid, .wr_ready, .wr_slot,
    .wr_data, .rd_slot, .rd_data, .wr_count, .rd_count, .ex_valid,
    .ex_ready, .ex_get, .ex_code, .ex_wdata, .ex_done, .ex_rdata,
    .comm_error, .key_switch, .net_error, .dup_error, .stopped, .mv_out,
    .bit_rate, .node_addr);
  fieldbus_master_model master (.aclk, .wr_valid, .wr_ready, .wr_slot,
    .wr_data, .rd_slot, .rd_data);
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [11:0] pa(input logic [5:0] c);
    return fieldbus_pkg::A_PARAM + {4'h0, c, 2'b00};
  endfunction
  // busy length of one written channel word
  function automatic int cost(input logic [3:0] s, input logic [15:0] d);
    if (s == 4'h3) return d[3] ? C_SAVE : C_INSTR;
    return backup ? C_BACK : C_RAM;
  endfunction
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access; reads compare data, all compare the response
  task automatic rw(input logic wr, input logic [11:0] a,
                    input logic [31:0] d, input logic [31:0] e);
    int n;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (arready === 1'b1) arvalid <= 1'b0;
      if ((wr ? bvalid : rvalid) === 1'b1) break;
    end
    chk(wr ? bresp : rresp, (a > 12'h1A0) ? fieldbus_pkg::RESP_SLVERR :
      fieldbus_pkg::RESP_OKAY);
    if (!wr) chk(rdata, e);
    bready <= 1'b0;
    rready <= 1'b0;
    #1;
    if (n == 99) miscompares++;
  endtask
  task automatic ex(input logic g, input logic [5:0] c,
                    input logic [15:0] d, output int t);
    @(posedge aclk);
    ex_get <= g;
    ex_code <= c;
    ex_wdata <= d;
    ex_valid <= 1'b1;
    for (t = 0; t < 99; t++) begin
      @(posedge aclk);
      if (ex_ready === 1'b1) break;
    end
    ex_valid <= 1'b0;
    ex_wdata <= ~d;
    if (t == 99) t = -1;
    else
      for (t = 0; t < 2000; t++) begin
        #1;
        if (ex_done === 1'b1) break;
        @(posedge aclk);
      end
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
  initial begin
    logic [15:0] v, h;
    logic [3:0] s;
    int t;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {ex_valid, ex_get, comm_error, key_switch} = 4'h0;
    {awaddr, araddr, wdata, wstrb, ex_code, ex_wdata} = {56'h0, 4'hF, 22'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(bit_rate, 32'h0);
    chk(node_addr, 32'h0);
    chk(wr_count, 32'h4);
    chk(rd_count, 32'h3);
    chk(dup_error, 32'h0);
    rw(1'b0, 12'hFFC, 32'h0, 32'h0);
    master.send(4'h0, rnd(), 0, t);
    chk(t, 0);
    rw(1'b0, pa(6'h06), 32'h0, 32'h0);
    rw(1'b1, fieldbus_pkg::A_MODE, 32'h1, 32'h0);
    for (int i = 0; i < 5; i++) begin
      s = tbl[i][19:16];
      v = (s == 4'h0) ? rnd() : tbl[i][15:0];
      master.send(s, v, i, t);
      chk(t, cost(s, v));
      if (s == 4'h3) backup = v[2];
      else h = v;
    end
    rw(1'b0, pa(6'h06), 32'h0, {16'h0, h});
    ex(1'b1, 6'h06, 16'h0, t);
    chk(t, C_GET);
    chk(ex_rdata, h);
    v = rnd();
    ex(1'b0, 6'h07, v, t);
    chk(t, C_SET);
    rw(1'b0, pa(6'h07), 32'h0, {16'h0, v});
    @(posedge aclk);
    key_switch <= 1'b1;
    repeat (4) @(posedge aclk);
    key_switch <= 1'b0;
    rw(1'b0, fieldbus_pkg::A_MODE, 32'h0, 32'h0);
    master.send(4'h3, 16'h0002, 1, t);
    chk(t, C_INSTR + C_KEY);
    rw(1'b0, fieldbus_pkg::A_MODE, 32'h0, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rw(1'b1, fieldbus_pkg::A_CONFIG, {22'h0, 6'h3F, 2'(i), 2'h0}, 32'h0);
      chk(bit_rate, (i == 3) ? 32'h2 : 32'(i));
      chk(node_addr, 32'h3F);
    end
    foreach (bad[i]) begin
      rw(1'b1, fieldbus_pkg::A_WSLOT, {26'h0, bad[i]}, 32'h0);
      rw(1'b0, fieldbus_pkg::A_WSLOT, 32'h0, 32'h6);
      rw(1'b0, fieldbus_pkg::A_STATUS, 32'h0, 32'h8);
      rw(1'b1, fieldbus_pkg::A_STATUS, 32'h8, 32'h0);
    end
    rw(1'b1, fieldbus_pkg::A_RSLOT, 32'h24, 32'h0);
    rw(1'b0, fieldbus_pkg::A_RSLOT, 32'h0, 32'h1);
    rw(1'b1, fieldbus_pkg::A_WSLOT + 12'h010, 32'h23, 32'h0);
    chk(wr_count, 32'h5);
    rw(1'b1, fieldbus_pkg::A_WSLOT + 12'h00C, 32'h0, 32'h0);
    rw(1'b1, fieldbus_pkg::A_WSLOT + 12'h010, 32'h0, 32'h0);
    chk(wr_count, 32'h3);
    master.send(4'h3, 16'h0002, 0, t);
    chk(t, 0);
    rw(1'b1, fieldbus_pkg::A_RSLOT + 12'h004, 32'h0, 32'h0);
    chk(rd_count, 32'h3);
    master.peek(4'h1, h);
    chk(h, 32'h0);
    v = rnd();
    rw(1'b1, pa(6'h25), {16'h0, v}, 32'h0);
    master.peek(4'h2, h);
    chk(h, v);
    rw(1'b1, pa(6'h01), {16'h0, v}, 32'h0);
    master.peek(4'h0, h);
    chk(h, v);
    rw(1'b1, fieldbus_pkg::A_CONFIG, 32'h1, 32'h0);
    rw(1'b1, pa(6'h01), 32'hFA24, 32'h0);
    master.peek(4'h0, h);
    chk(h, 32'hA500);
    rw(1'b1, pa(6'h01), 32'hFFF1, 32'h0);
    master.peek(4'h0, h);
    chk(h, 32'hF015);
    rw(1'b1, fieldbus_pkg::A_STOP_MV, {16'h0, v}, 32'h0);
    @(posedge aclk);
    comm_error <= 1'b1;
    repeat (6) @(posedge aclk);
    #1;
    chk(stopped, 32'h0);
    rw(1'b1, fieldbus_pkg::A_CONFIG, 32'h2, 32'h0);
    repeat (4) @(posedge aclk);
    #1;
    chk(stopped, 32'h1);
    chk(mv_out, v);
    chk(net_error, 32'h0);
    for (int i = 0; i < 32; i++)
      rw(1'b1, fieldbus_pkg::A_WSLOT + 12'(4 * i), 32'h0, 32'h0);
    chk(net_error, 32'h1);
    complete_run();
  end
endmodule
